// *** spc_pkg.sv ***
package spc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SPC_OFS_SLEEP_CFG = 8'h40;
    localparam logic [7:0] SPC_OFS_KEEP_ON = 8'h41;

    // Field positions of the sleep/power configuration register.
    localparam int SPC_BIT_RSVD = 7;
    localparam int SPC_BIT_SLEEP_LVL = 6;
    localparam int SPC_BIT_SLOT_HI = 5;
    localparam int SPC_BIT_SLOT_LO = 4;
    localparam int SPC_BIT_SLEEP_POL = 3;
    localparam int SPC_BIT_LP_OFF = 2;
    localparam int SPC_BIT_LP_RST = 1;
    localparam int SPC_BIT_IRQ_POL = 0;

    // Reset values; bit 7 is not stored.
    localparam logic [6:0] SPC_SLEEP_CFG_RST = 7'h34;
    localparam logic [7:0] SPC_KEEP_ON_RST = 8'h00;
    // Fields that boot configuration reloads.
    localparam logic [6:0] SPC_BOOT_MASK = 7'h37;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SPC_CLK_PERIOD_NS = 10;
    localparam int SPC_SLOT_A_US = 200;
    localparam int SPC_SLOT_B_US = 500;
    localparam int SPC_SLOT_C_MS = 2;
    localparam int SPC_LONG_PRESS_MS = 1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SPC_SLOT_ZERO = 2'h0,
        SPC_SLOT_A = 2'h1,
        SPC_SLOT_B = 2'h2,
        SPC_SLOT_C = 2'h3
    } spc_slot_t;

    typedef enum logic [2:0] {
        SPC_LP_IDLE = 3'h1,
        SPC_LP_HOLD = 3'h2,
        SPC_LP_FIRED = 3'h4
    } spc_lp_state_t;

    // Keep-on register bit that belongs to LDO number n (1 to 8).
    function automatic int spc_keep_bit(input int n);
        case (n)
            1: return 1;
            2: return 2;
            3: return 7;
            4: return 6;
            5: return 3;
            6: return 0;
            7: return 5;
            default: return 4;
        endcase
    endfunction

endpackage

// *** spc_cfg_if.sv ***
// Configuration handed from the register bank to its helpers.
interface spc_cfg_if;
    logic [1:0] slot_sel;
    logic [7:0] keep_by_ldo;
    logic [7:0] en1_assign;
    logic [7:0] ldo_enabled;
    logic en1_level;
    logic in_sleep;

    modport src (output slot_sel, keep_by_ldo, en1_assign, ldo_enabled,
                 en1_level, in_sleep);
    modport slot (input slot_sel);
    modport ldo (input keep_by_ldo, en1_assign, ldo_enabled, en1_level,
                 in_sleep);
endinterface

// *** spc_slot_timer.sv ***
// Produces one tick per power-sequence time slot while running.
module spc_slot_timer #(
    parameter int SLOT_A_CYC = 20000,
    parameter int SLOT_B_CYC = 50000,
    parameter int SLOT_C_CYC = 200000
) (
    input logic clk_sys_in,
    input logic srst_in,
    spc_cfg_if.slot cfg,
    input logic run_in,
    output logic tick_out
);
    typedef struct packed {
        logic [17:0] cnt;
        logic tick;
    } spc_tmr_st_t;

    spc_tmr_st_t st_r;
    spc_tmr_st_t st_nxt;
    logic [17:0] lim;

    // Slot length select and counting.
    always_comb begin
        st_nxt = st_r;
        case (cfg.slot_sel) // see [RULE_02]
            spc_pkg::SPC_SLOT_A: lim = 18'(SLOT_A_CYC - 1);
            spc_pkg::SPC_SLOT_B: lim = 18'(SLOT_B_CYC - 1);
            default: lim = 18'(SLOT_C_CYC - 1);
        endcase
        st_nxt.tick = 1'b0;
        if (!run_in) begin
            st_nxt.cnt = '0;
        end else if (cfg.slot_sel == spc_pkg::SPC_SLOT_ZERO) begin
            st_nxt.tick = 1'b1;
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= lim) begin
            st_nxt.tick = 1'b1;
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 18'h1;
        end
    end

    // State register.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    zero_slot_tick_a: assert property ( // see [RULE_02]
        run_in && cfg.slot_sel == spc_pkg::SPC_SLOT_ZERO |=> tick_out)
        else $error("zero slot gave no tick");
endmodule

// *** spc_ldo_ctrl.sv ***
// Decides on/off and full-load state of each LDO (index 0 is LDO1).
module spc_ldo_ctrl (
    input logic clk_sys_in,
    input logic srst_in,
    spc_cfg_if.ldo cfg,
    output logic [7:0] ldo_on_out,
    output logic [7:0] ldo_full_load_out
);
    typedef struct packed {
        logic [7:0] on;
        logic [7:0] full;
    } spc_ldo_st_t;

    spc_ldo_st_t st_r;
    spc_ldo_st_t st_nxt;

    // Per-regulator supply state.
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < 8; i++) begin
            if (cfg.en1_assign[i]) begin
                // Line high: fully on; line low: keep bit decides.
                st_nxt.on[i] = cfg.en1_level | cfg.keep_by_ldo[i]; // see [RULE_10] see [RULE_11]
                st_nxt.full[i] = st_nxt.on[i];
            end else begin
                // An off regulator stays off whatever the keep bit.
                st_nxt.on[i] = cfg.ldo_enabled[i]; // see [RULE_09]
                st_nxt.full[i] = cfg.ldo_enabled[i] &
                    (~cfg.in_sleep | cfg.keep_by_ldo[i]); // see [RULE_07] see [RULE_08]
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ldo_on_out = st_r.on;
    assign ldo_full_load_out = st_r.full;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    en1_high_on_a: assert property ( // see [RULE_10]
        cfg.en1_level |=>
        (ldo_on_out & $past(cfg.en1_assign)) == $past(cfg.en1_assign))
        else $error("enable-1 ldo not on with line high");
    en1_low_off_a: assert property ( // see [RULE_11]
        !cfg.en1_level |=> (ldo_on_out & $past(cfg.en1_assign)) ==
        $past(cfg.en1_assign & cfg.keep_by_ldo))
        else $error("enable-1 ldo wrong with line low");
    sleep_full_a: assert property ( // see [RULE_08]
        cfg.in_sleep |=> (ldo_full_load_out & ~$past(cfg.en1_assign)) ==
        $past(cfg.ldo_enabled & cfg.keep_by_ldo & ~cfg.en1_assign))
        else $error("sleep load mode wrong");
endmodule

// *** spc_sleep_power_regs.sv ***
// Behaviour
// [RULE_01] Sleep-level bit set makes converters use a nonzero sleep voltage.
// [RULE_02] Slot field picks a sequence slot of 0, 200 us, 500 us or 2 ms.
// [RULE_03] Sleep polarity bit set means the sleep input is active high.
// [RULE_04] Long-press bit set turns the device off after a long low press.
// [RULE_05] Core-reset bit set allows a digital core reset while in OFF.
// [RULE_06] Interrupt polarity bit 0 gives an active-low pad, 1 active-high.
// [RULE_07] Keep-on bit set keeps an LDO at full load through sleep.
// [RULE_08] Keep-on bit clear puts an LDO in low-power mode during sleep.
// [RULE_09] A keep-on bit has no effect on a regulator that is off.
// [RULE_10] An enable-1 LDO is fully on whenever the enable-1 line is high.
// [RULE_11] With enable-1 low an assigned LDO is off or full by its keep bit.
// [RULE_12] Keep-on bits 7 to 0 are LDO3,4,7,8,5,2,1,6 and reset to zero.
// [RULE_13] Both registers are written by the host over the control bus.
// [RULE_14] Reserved bit 7 of the configuration ignores writes, reads zero.
module spc_sleep_power_regs #(
    parameter int SLOT_A_CYC =
        spc_pkg::SPC_SLOT_A_US * 1000 / spc_pkg::SPC_CLK_PERIOD_NS,
    parameter int SLOT_B_CYC =
        spc_pkg::SPC_SLOT_B_US * 1000 / spc_pkg::SPC_CLK_PERIOD_NS,
    parameter int SLOT_C_CYC =
        spc_pkg::SPC_SLOT_C_MS * 1000000 / spc_pkg::SPC_CLK_PERIOD_NS,
    parameter int LONG_PRESS_CYC =
        spc_pkg::SPC_LONG_PRESS_MS * 1000000 / spc_pkg::SPC_CLK_PERIOD_NS
) (
    input logic clk_sys_in,
    input logic srst_in,
    input logic reg_wr_en_in,
    input logic reg_rd_en_in,
    input logic [7:0] reg_addr_in,
    input logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input logic boot_load_in,
    input logic [7:0] boot_cfg_in,
    input logic sleep_req_pin_in,
    input logic power_button_input_in,
    input logic enable1_line_in,
    input logic in_sleep_in,
    input logic off_state_in,
    input logic irq_event_in,
    input logic [7:0] core_rail_sleep_voltage_in,
    input logic [7:0] enable1_ldo_assignment_in,
    input logic [7:0] ldo_enabled_in,
    input logic seq_run_in,
    output logic converter_sleep_level_sel_out,
    output logic [1:0] sequence_slot_duration_out,
    output logic sleep_req_out,
    output logic irq_output_pad_out,
    output logic long_press_turnoff_out,
    output logic off_state_core_reset_out,
    output logic dcdc_use_sleep_level_out,
    output logic slot_tick_out,
    output logic [7:0] ldo_on_out,
    output logic [7:0] ldo_full_load_out
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [6:0] cfg;
        logic [7:0] keep;
        logic [7:0] rdata;
        logic [1:0] slp_s;
        logic [1:0] pwr_s;
        logic [1:0] en1_s;
        logic sleep_req;
        logic irq_pad;
        spc_pkg::spc_lp_state_t lp;
        logic [19:0] lp_cnt;
        logic turnoff;
        logic core_rst;
        logic dcdc_lvl;
    } spc_main_st_t;

    spc_main_st_t st_r;
    spc_main_st_t st_nxt;
    spc_cfg_if cfg_if ();

    // ****************************************
    // Next-state logic
    // ****************************************

    // Registers, synchronisers, polarity and long-press detection.
    always_comb begin
        st_nxt = st_r;

        // Pin synchronisers; only the second stage is read.
        st_nxt.slp_s = {st_r.slp_s[0], sleep_req_pin_in};
        st_nxt.pwr_s = {st_r.pwr_s[0], power_button_input_in};
        st_nxt.en1_s = {st_r.en1_s[0], enable1_line_in};

        // Boot configuration reloads its fields; a host write wins.
        if (boot_load_in) begin // see [RULE_02] see [RULE_04]
            st_nxt.cfg = (st_r.cfg & ~spc_pkg::SPC_BOOT_MASK) |
                (boot_cfg_in[6:0] & spc_pkg::SPC_BOOT_MASK);
        end

        // Host writes over the control serial bus.
        if (reg_wr_en_in) begin // see [RULE_13]
            if (reg_addr_in == spc_pkg::SPC_OFS_SLEEP_CFG) begin
                st_nxt.cfg = reg_wdata_in[6:0]; // see [RULE_14]
            end else if (reg_addr_in == spc_pkg::SPC_OFS_KEEP_ON) begin
                st_nxt.keep = reg_wdata_in; // see [RULE_12]
            end
        end

        // Reads answer one cycle later; unmapped reads give zero.
        if (reg_rd_en_in) begin
            if (reg_addr_in == spc_pkg::SPC_OFS_SLEEP_CFG) begin
                st_nxt.rdata = {1'b0, st_r.cfg}; // see [RULE_14]
            end else if (reg_addr_in == spc_pkg::SPC_OFS_KEEP_ON) begin
                st_nxt.rdata = st_r.keep;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // Sleep request is asserted when the pin equals the polarity bit.
        st_nxt.sleep_req = st_r.slp_s[1] ==
            st_r.cfg[spc_pkg::SPC_BIT_SLEEP_POL]; // see [RULE_03]

        // Interrupt pad: active high when the bit is 1, else active low.
        st_nxt.irq_pad = irq_event_in ==
            st_r.cfg[spc_pkg::SPC_BIT_IRQ_POL]; // see [RULE_06]

        // Core reset in OFF is allowed only when enabled.
        st_nxt.core_rst = off_state_in &
            st_r.cfg[spc_pkg::SPC_BIT_LP_RST]; // see [RULE_05]

        // Sleep voltage is used only if selected and nonzero.
        st_nxt.dcdc_lvl = in_sleep_in &
            st_r.cfg[spc_pkg::SPC_BIT_SLEEP_LVL] &
            (core_rail_sleep_voltage_in != 8'h00); // see [RULE_01]

        // Long press: button held low for the full hold time.
        st_nxt.turnoff = 1'b0;
        case (st_r.lp)
            spc_pkg::SPC_LP_IDLE: begin
                st_nxt.lp_cnt = '0;
                if (!st_r.pwr_s[1]) begin
                    st_nxt.lp = spc_pkg::SPC_LP_HOLD;
                end
            end
            spc_pkg::SPC_LP_HOLD: begin
                if (st_r.pwr_s[1]) begin
                    st_nxt.lp = spc_pkg::SPC_LP_IDLE;
                end else if (st_r.lp_cnt >= 20'(LONG_PRESS_CYC - 1)) begin
                    st_nxt.turnoff =
                        st_r.cfg[spc_pkg::SPC_BIT_LP_OFF]; // see [RULE_04]
                    st_nxt.lp = spc_pkg::SPC_LP_FIRED;
                end else begin
                    st_nxt.lp_cnt = st_r.lp_cnt + 20'h1;
                end
            end
            spc_pkg::SPC_LP_FIRED: begin
                if (st_r.pwr_s[1]) begin
                    st_nxt.lp = spc_pkg::SPC_LP_IDLE;
                end
            end
            default: begin
                st_nxt.lp = spc_pkg::SPC_LP_IDLE;
            end
        endcase
    end

    // State register with its reset values.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_r <= '0;
            st_r.irq_pad <= 1'b1; // Idle level of the default low pad.
            st_r.cfg <= spc_pkg::SPC_SLEEP_CFG_RST;
            st_r.keep <= spc_pkg::SPC_KEEP_ON_RST; // see [RULE_12]
            st_r.slp_s <= 2'h3;
            st_r.pwr_s <= 2'h3;
            st_r.lp <= spc_pkg::SPC_LP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************

    // Keep-on bits reordered to LDO numbering.
    generate
        for (genvar g = 0; g < 8; g++) begin : g_map
            assign cfg_if.keep_by_ldo[g] =
                st_r.keep[spc_pkg::spc_keep_bit(g + 1)]; // see [RULE_12]
        end
    endgenerate

    // Configuration handed to the helpers.
    assign cfg_if.slot_sel =
        st_r.cfg[spc_pkg::SPC_BIT_SLOT_HI:spc_pkg::SPC_BIT_SLOT_LO];
    assign cfg_if.en1_assign = enable1_ldo_assignment_in;
    assign cfg_if.ldo_enabled = ldo_enabled_in;
    assign cfg_if.en1_level = st_r.en1_s[1];
    assign cfg_if.in_sleep = in_sleep_in;

    // Sequence slot timer.
    spc_slot_timer #(
        .SLOT_A_CYC(SLOT_A_CYC),
        .SLOT_B_CYC(SLOT_B_CYC),
        .SLOT_C_CYC(SLOT_C_CYC)
    ) u_slot (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .cfg(cfg_if.slot),
        .run_in(seq_run_in),
        .tick_out(slot_tick_out)
    );

    // LDO sleep and enable-1 control.
    spc_ldo_ctrl u_ldo (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .cfg(cfg_if.ldo),
        .ldo_on_out(ldo_on_out),
        .ldo_full_load_out(ldo_full_load_out)
    );

    // ****************************************
    // Outputs
    // ****************************************

    // Every output assigned here comes straight from the state register.
    assign reg_rdata_out = st_r.rdata;
    assign converter_sleep_level_sel_out =
        st_r.cfg[spc_pkg::SPC_BIT_SLEEP_LVL];
    assign sequence_slot_duration_out =
        st_r.cfg[spc_pkg::SPC_BIT_SLOT_HI:spc_pkg::SPC_BIT_SLOT_LO];
    assign sleep_req_out = st_r.sleep_req;
    assign irq_output_pad_out = st_r.irq_pad;
    assign long_press_turnoff_out = st_r.turnoff;
    assign off_state_core_reset_out = st_r.core_rst;
    assign dcdc_use_sleep_level_out = st_r.dcdc_lvl;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    reserved_reads_zero_a: assert property ( // see [RULE_14]
        reg_rd_en_in && reg_addr_in == spc_pkg::SPC_OFS_SLEEP_CFG
        |=> reg_rdata_out[7] == 1'b0)
        else $error("reserved bit read nonzero");
    cfg_write_a: assert property ( // see [RULE_02]
        reg_wr_en_in && reg_addr_in == spc_pkg::SPC_OFS_SLEEP_CFG
        |=> sequence_slot_duration_out == $past(reg_wdata_in[5:4]))
        else $error("slot field write lost");
    keep_write_a: assert property ( // see [RULE_13]
        reg_wr_en_in && reg_addr_in == spc_pkg::SPC_OFS_KEEP_ON
        |=> st_r.keep == $past(reg_wdata_in))
        else $error("keep-on write lost");
    sleep_polarity_a: assert property ( // see [RULE_03]
        ##1 sleep_req_out == ($past(st_r.slp_s[1]) ==
        $past(st_r.cfg[spc_pkg::SPC_BIT_SLEEP_POL])))
        else $error("sleep polarity wrong");
    irq_polarity_a: assert property ( // see [RULE_06]
        ##1 irq_output_pad_out == ($past(irq_event_in) ==
        $past(st_r.cfg[spc_pkg::SPC_BIT_IRQ_POL])))
        else $error("interrupt pad polarity wrong");
    long_press_off_a: assert property ( // see [RULE_04]
        long_press_turnoff_out |-> st_r.lp == spc_pkg::SPC_LP_FIRED &&
        $past(st_r.cfg[spc_pkg::SPC_BIT_LP_OFF]) && !$past(st_r.pwr_s[1]))
        else $error("turn-off without long press");
    core_reset_a: assert property ( // see [RULE_05]
        off_state_in && st_r.cfg[spc_pkg::SPC_BIT_LP_RST]
        |=> off_state_core_reset_out)
        else $error("core reset not allowed in off");
    dcdc_level_a: assert property ( // see [RULE_01]
        dcdc_use_sleep_level_out |-> $past(in_sleep_in) &&
        $past(core_rail_sleep_voltage_in) != 8'h00)
        else $error("sleep level with zero voltage");
    keep_reset_a: assert property ( // see [RULE_12]
        $fell(srst_in) |-> st_r.keep == spc_pkg::SPC_KEEP_ON_RST)
        else $error("keep-on not zero after reset");
    // Refused reads, boot reload, reset gating, sleep-level use and idle regulators.
    unmapped_read_a: assert property ( // see [RULE_13]
        reg_rd_en_in && reg_addr_in != spc_pkg::SPC_OFS_SLEEP_CFG &&
        reg_addr_in != spc_pkg::SPC_OFS_KEEP_ON |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    boot_slot_load_a: assert property ( // see [RULE_02]
        boot_load_in && !reg_wr_en_in
        |=> sequence_slot_duration_out == $past(boot_cfg_in[5:4]))
        else $error("boot slot field not loaded");
    core_reset_idle_a: assert property ( // see [RULE_05]
        !off_state_in |=> !off_state_core_reset_out)
        else $error("core reset allowed outside off");
    sleep_level_used_a: assert property ( // see [RULE_01]
        in_sleep_in && converter_sleep_level_sel_out &&
        core_rail_sleep_voltage_in != 8'h00 |=> dcdc_use_sleep_level_out)
        else $error("sleep level not used");
    off_ldo_idle_a: assert property ( // see [RULE_09]
        ##1 ((ldo_on_out | ldo_full_load_out) &
        ~$past(ldo_enabled_in | enable1_ldo_assignment_in)) == 8'h00)
        else $error("switched-off ldo came up");

    long_press_c: cover property (long_press_turnoff_out);
    sleep_req_c: cover property (sleep_req_out && in_sleep_in);
    dcdc_level_c: cover property (dcdc_use_sleep_level_out);
    slot_tick_c: cover property (slot_tick_out ##1 !slot_tick_out);
endmodule

// *** spc_host_model.sv ***
// ****************************************
// Host-side pins of the power block
// ****************************************
module spc_host_model (
    input wire logic clk_sys_in,
    output logic sleep_pin_out,
    output logic button_out,
    output logic en1_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins idle with the button released and the sleep line high.
    initial begin
        sleep_pin_out = 1'b1;
        button_out = 1'b1;
        en1_out = 1'b0;
    end

    // Moves all three pins together just after a clock edge.
    task automatic set_pins(input logic s, input logic b, input logic e);
        @(posedge clk_sys_in);
        #1;
        sleep_pin_out = s;
        button_out = b;
        en1_out = e;
    endtask
endmodule

// *** test_sleep_power_config_regs.sv ***
module test_sleep_power_config_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int MAP [8] = '{1, 2, 7, 6, 3, 0, 5, 4};
    localparam int SL [4] = '{1, 5, 8, 12};
    logic clk_sys_in = 1'b0, srst_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic boot_ld = 1'b0, in_sleep = 1'b0, off_st = 1'b0, irq_ev = 1'b0;
    logic seq_run = 1'b0, lvl, sreq, pad, lp_off, crst, dcdc, tick;
    logic sleep_pin, button, en1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, boot_cfg = 8'h00;
    logic [7:0] volt = 8'h00, asg = 8'h00, ldo_en = 8'h00;
    logic [7:0] rdata, ldo_on, ldo_full, d;
    logic [1:0] slot;
    int errors = 0, n_checks = 0, cyc = 0;

    spc_host_model host (.clk_sys_in(clk_sys_in), .sleep_pin_out(sleep_pin),
        .button_out(button), .en1_out(en1));

    spc_sleep_power_regs #(.SLOT_A_CYC(5), .SLOT_B_CYC(8), .SLOT_C_CYC(12),
        .LONG_PRESS_CYC(10)) dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .boot_load_in(boot_ld), .boot_cfg_in(boot_cfg),
        .sleep_req_pin_in(sleep_pin), .power_button_input_in(button),
        .enable1_line_in(en1), .in_sleep_in(in_sleep),
        .off_state_in(off_st), .irq_event_in(irq_ev),
        .core_rail_sleep_voltage_in(volt),
        .enable1_ldo_assignment_in(asg), .ldo_enabled_in(ldo_en),
        .seq_run_in(seq_run), .converter_sleep_level_sel_out(lvl),
        .sequence_slot_duration_out(slot), .sleep_req_out(sreq),
        .irq_output_pad_out(pad), .long_press_turnoff_out(lp_off),
        .off_state_core_reset_out(crst), .dcdc_use_sleep_level_out(dcdc),
        .slot_tick_out(tick), .ldo_on_out(ldo_on),
        .ldo_full_load_out(ldo_full));

    // The clock toggles every half period of 5 ns.
    always #5 clk_sys_in = ~clk_sys_in;

    // A hang is cut short after a fixed number of cycles.
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // A write holds its strobe over one edge, then idles one cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wr_en = 1'b1;
        addr = a;
        wdata = v;
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        rd_en = 1'b1;
        addr = a;
        step(1);
        rd_en = 1'b0;
        step(1);
        v = rdata;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(8'h40, d);
        chk(d, 8'h34);
        rd(8'h41, d);
        chk(d, 8'h00);
        rd(8'h42, d);
        chk(d, 8'h00);
        wr(8'h40, 8'hFF);
        rd(8'h40, d);
        chk(d, 8'h7F);
        chk({5'h00, lvl, slot}, 8'h07);
        wr(8'h43, 8'hFF);
        wr(8'h41, 8'hA5);
        rd(8'h41, d);
        chk(d, 8'hA5);
        $display("test regs done");
    endtask

    // Boot load of all ones sets every boot-configured field to 1.
    task automatic t_boot();
        wr(8'h40, 8'h48);
        boot_cfg = 8'hFF;
        boot_ld = 1'b1;
        step(1);
        boot_ld = 1'b0;
        rd(8'h40, d);
        chk(d, 8'h7F);
        $display("test boot done");
    endtask

    task automatic t_pins();
        irq_ev = 1'b1;
        in_sleep = 1'b1;
        off_st = 1'b1;
        volt = 8'h20;
        wr(8'h40, 8'h4B);
        host.set_pins(1'b1, 1'b1, 1'b0);
        step(5);
        chk({4'h0, pad, sreq, dcdc, crst}, 8'h0F);
        volt = 8'h00;
        step(2);
        chk({7'h00, dcdc}, 8'h00);
        wr(8'h40, 8'h00);
        host.set_pins(1'b0, 1'b1, 1'b0);
        step(5);
        chk({4'h0, pad, sreq, dcdc, crst}, 8'h04);
        host.set_pins(1'b1, 1'b1, 1'b0);
        step(5);
        chk({7'h00, sreq}, 8'h00);
        $display("test pins done");
    endtask

    task automatic t_ldo();
        ldo_en = 8'hFF;
        asg = 8'h00;
        for (int n = 0; n < 8; n++) begin
            wr(8'h41, 8'h01 << MAP[n]);
            step(2);
            chk(ldo_full, 8'h01 << n);
            chk(ldo_on, 8'hFF);
        end
        ldo_en = 8'h00;
        step(2);
        chk(ldo_full | ldo_on, 8'h00);
        asg = 8'hFF;
        wr(8'h41, 8'h80);
        step(2);
        chk(ldo_on & ldo_full, 8'h04);
        chk(ldo_on | ldo_full, 8'h04);
        host.set_pins(1'b1, 1'b1, 1'b1);
        step(5);
        chk(ldo_on & ldo_full, 8'hFF);
        host.set_pins(1'b1, 1'b1, 1'b0);
        $display("test ldo done");
    endtask

    // Measures the gap between two slot ticks for every setting.
    task automatic t_slot();
        int n;
        for (int s = 0; s < 4; s++) begin
            wr(8'h40, {2'b00, 2'(s), 4'h0});
            seq_run = 1'b1;
            n = 0;
            do begin
                step(1);
                n++;
            end while (tick !== 1'b1 && n < 40);
            n = 0;
            do begin
                step(1);
                n++;
            end while (tick !== 1'b1 && n < 40);
            chk(8'(n), 8'(SL[s]));
            seq_run = 1'b0;
        end
        $display("test slot done");
    endtask

    // Holds the button low well past the press time and counts pulses.
    task automatic t_press(input logic [7:0] cfg, input int exp);
        int p;
        p = 0;
        wr(8'h40, cfg);
        host.set_pins(1'b1, 1'b0, 1'b0);
        repeat (40) begin
            step(1);
            if (lp_off === 1'b1) p++;
        end
        host.set_pins(1'b1, 1'b1, 1'b0);
        step(5);
        chk(8'(p), 8'(exp));
        $display("test press done");
    endtask

    // Reset is held for ten cycles, then every scenario runs in turn.
    initial begin
        step(10);
        srst_in = 1'b0;
        step(1);
        t_regs();
        t_boot();
        t_pins();
        t_ldo();
        t_slot();
        t_press(8'h04, 1);
        t_press(8'h00, 0);
        tally_and_finish();
    end
endmodule
